/* hdl/src_consts.svh */
// Offsets, field positions, reset values and counts of the reset combiner.
// Assumes only the low 16 address bits reach the combiner's decoder.
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH
`define SRC_OFF_CAUSE 16'hF600
`define SRC_OFF_TRIG 16'hF610
`define SRC_OFF_IRQ_STAT 16'hF620
`define SRC_OFF_IRQ_MASK 16'hF630
`define SRC_OFF_CLR_ALIAS 16'h0004
`define SRC_BIT_POR 0
`define SRC_BIT_BOR 1
`define SRC_BIT_IDLE 2
`define SRC_BIT_SLEEP 3
`define SRC_BIT_WATCHDOG_TIMEOUT_FLAG 4
`define SRC_BIT_SWR 6
`define SRC_BIT_EXTERNAL_PIN_FLAG 7
`define SRC_BIT_REGULATOR_STANDBY_KEEP_ON 8
`define SRC_BIT_CMR 9
`define SRC_BIT_TRIG 0
`define SRC_CAUSE_MASK 16'h03DF
`define SRC_CAUSE_POR_VALUE 16'h0003
`define SRC_UPPER_RESET 16'h0000
`define SRC_REQ_IDLE 5'h02
`define SRC_SW_HOLD_CYCLES 4'h4
`define SRC_HTRANS_ACTIVE_BIT 1
`endif

/* hdl/src_pkg.sv */
// Types shared by the reset combiner and its bench.
// Assumes the constants header is compiled alongside.
package src_pkg;
  // Decoded alias slot: base, clear, set and invert, in address order.
  typedef enum logic [1:0] {SRC_ALIAS_BASE, SRC_ALIAS_CLR, SRC_ALIAS_SET, SRC_ALIAS_INV} src_alias_t;
  // Raw reset requests from the source detectors and the pin.
  typedef struct packed {
    logic cfgMismatch;
    logic brownOut;
    logic watchdog;
    logic extPinN;
    logic powerOn;
  } src_req_t;
  // AHB-Lite slave request signals.
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } src_ahb_req_t;
  // AHB-Lite slave response signals.
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } src_ahb_rsp_t;
  // Whole state of the combiner.
  typedef struct packed {
    src_req_t syncA;
    src_req_t syncB;
    logic [15:0] cause;
    logic [15:0] irqStat;
    logic [15:0] irqMask;
    logic [3:0] swCount;
    logic mstRstN;
    logic irq;
    logic dpWrite;
    logic [15:0] dpAddr;
    logic [31:0] hrdata;
  } src_state_t;
endpackage

/* hdl/src_reset_combiner.sv */
// Reset combiner: merges the reset sources into one master reset, keeps
// the reset cause flags, the regulator standby bit and a software trigger.
// Assumes a single AHB-Lite master and the source detectors outside.
`timescale 1ns/1ps
`include "src_consts.svh"

// Behaviour
// - Any source request drives one master reset.
// - Six sources each assert the master reset.
// - Clear, set, invert aliases at plus 4/8/C.
// - Status at F600, trigger at F610; upper zero.
// - Mismatch flag bit 9, hardware set, POR cleared.
// - Regulator standby bit 8, read/write, resets zero.
// - External pin reset sets bit 7.
// - Software reset sets bit 6.
// - Watchdog time-out sets bit 4.
// - Wake from Sleep sets bit 3.
// - Wake from Idle sets bit 2.
// - Brown-out sets bit 1; one after power-on.
// - Power-on sets bit 0; one after power-up.
// - Unimplemented status bits read zero, ignore writes.
// - Status reset value depends on reset kind.
// - Trigger bit starts software reset, reads zero.
module src_reset_combiner #(
  parameter logic [3:0] SW_HOLD = `SRC_SW_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire src_pkg::src_ahb_req_t ahbReq,
  output src_pkg::src_ahb_rsp_t ahbRsp,
  input wire src_pkg::src_req_t srcReq,
  input wire logic sleepMode,
  input wire logic idleMode,
  input wire logic wakeEvent,
  output logic masterSystemResetN,
  output logic regulatorStandbyKeepOn,
  output logic irq
);

  // Two-stage release of the local reset; stage 0 feeds stage 1 only.
  logic [1:0] rstSync;
  // Local reset, asserted asynchronously and released on a clock edge.
  logic rstLocalN;
  // Registered and next state of the whole block.
  src_pkg::src_state_t s_q;
  src_pkg::src_state_t s_d;
  // Synchronised, active-high requests from outside.
  logic porReq;
  logic extReq;
  logic wdtReq;
  logic borReq;
  logic cmrReq;
  // Bus decode of the address phase now and of the data phase that is completing now.
  logic [15:0] dpBase;
  src_pkg::src_alias_t dpAlias;
  logic addrPhase;
  logic causeWr;
  logic statWr;
  logic maskWr;
  logic trigger;
  // Any reset request in this cycle, including the software stretch.
  logic anyReq;
  // Master reset goes from released to asserted in this cycle.
  logic rstEvent;
  // Hardware set vector of the cause flags.
  logic [15:0] hwSet;

  // Applies the base, clear, set or invert alias to one register.
  function automatic logic [15:0] aliasApply(
    input logic [15:0] q,
    input logic [15:0] w,
    input src_pkg::src_alias_t a
  );
    logic [15:0] r;
    r = q;
    case (a)
      src_pkg::SRC_ALIAS_BASE: r = w;
      src_pkg::SRC_ALIAS_CLR: r = q & ~w;
      src_pkg::SRC_ALIAS_SET: r = q | w;
      src_pkg::SRC_ALIAS_INV: r = q ^ w;
      default: r = q;
    endcase
    return r;
  endfunction

  // Read multiplexer; alias and unmapped addresses read as zero.
  function automatic logic [31:0] readReg(
    input logic [15:0] addr,
    input src_pkg::src_state_t s
  );
    logic [31:0] r;
    r = 32'h00000000;
    case (addr)
      `SRC_OFF_CAUSE: r = {`SRC_UPPER_RESET, s.cause};
      `SRC_OFF_TRIG: r = 32'h00000000;
      `SRC_OFF_IRQ_STAT: r = {`SRC_UPPER_RESET, s.irqStat};
      `SRC_OFF_IRQ_MASK: r = {`SRC_UPPER_RESET, s.irqMask};
      default: r = 32'h00000000;
    endcase
    return r;
  endfunction

  // Reset release synchroniser: assertion is immediate, release waits two edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstLocalN = rstSync[1];

  // Requests seen only after both synchroniser stages.
  assign porReq = s_q.syncB.powerOn;
  assign extReq = ~s_q.syncB.extPinN;
  assign wdtReq = s_q.syncB.watchdog;
  assign borReq = s_q.syncB.brownOut;
  assign cmrReq = s_q.syncB.cfgMismatch;

  // The alias slot sits in address bits 3:2 of every register base.
  assign dpBase = {s_q.dpAddr[15:4], 4'h0};
  assign dpAlias = src_pkg::src_alias_t'(s_q.dpAddr[3:2]);
  assign addrPhase = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[`SRC_HTRANS_ACTIVE_BIT];
  assign causeWr = s_q.dpWrite && (dpBase == `SRC_OFF_CAUSE);
  assign statWr = s_q.dpWrite && (dpBase == `SRC_OFF_IRQ_STAT);
  assign maskWr = s_q.dpWrite && (dpBase == `SRC_OFF_IRQ_MASK);
  // A clear alias write can only lower the bit, so it never fires.
  assign trigger = s_q.dpWrite && (dpBase == `SRC_OFF_TRIG)
                   && (dpAlias != src_pkg::SRC_ALIAS_CLR)
                   && ahbReq.hwdata[`SRC_BIT_TRIG];

  // Every source, and the software stretch, asserts the master reset.
  assign anyReq = porReq | extReq | wdtReq | borReq | cmrReq | trigger
                  | (s_q.swCount != 4'h0);
  assign rstEvent = s_q.mstRstN & anyReq;

  // Next-state logic of the whole block.
  always_comb begin
    s_d = s_q;
    // Second stage reads the first; nothing else looks at stage one.
    s_d.syncA = srcReq;
    s_d.syncB = s_q.syncA;

    // Hardware set sources of the cause flags.
    hwSet = 16'h0000;
    hwSet[`SRC_BIT_POR] = porReq;
    hwSet[`SRC_BIT_BOR] = borReq | porReq;
    hwSet[`SRC_BIT_IDLE] = idleMode & (wakeEvent | rstEvent);
    hwSet[`SRC_BIT_SLEEP] = sleepMode & (wakeEvent | rstEvent);
    hwSet[`SRC_BIT_WATCHDOG_TIMEOUT_FLAG] = wdtReq;
    hwSet[`SRC_BIT_SWR] = trigger;
    hwSet[`SRC_BIT_EXTERNAL_PIN_FLAG] = extReq;
    hwSet[`SRC_BIT_CMR] = cmrReq;

    // Software write first, hardware set second, so a set beats a clear.
    if (causeWr) begin
      s_d.cause = aliasApply(s_q.cause, ahbReq.hwdata[15:0], dpAlias);
    end
    // A power-on restarts the cause record from its power-on image.
    if (porReq) begin
      s_d.cause = `SRC_CAUSE_POR_VALUE;
    end else begin
      s_d.cause = s_d.cause | hwSet;
    end
    // Unimplemented bits never hold a one.
    s_d.cause = s_d.cause & `SRC_CAUSE_MASK;

    // Interrupt status: a base write is write-one-to-clear.
    if (statWr) begin
      if (dpAlias == src_pkg::SRC_ALIAS_BASE) begin
        s_d.irqStat = s_q.irqStat & ~ahbReq.hwdata[15:0];
      end else begin
        s_d.irqStat = aliasApply(s_q.irqStat, ahbReq.hwdata[15:0], dpAlias);
      end
    end
    s_d.irqStat = (s_d.irqStat | hwSet) & `SRC_CAUSE_MASK;
    // Mask register shares the status layout.
    if (maskWr) begin
      s_d.irqMask = aliasApply(s_q.irqMask, ahbReq.hwdata[15:0], dpAlias) & `SRC_CAUSE_MASK;
    end
    s_d.irq = |(s_d.irqStat & s_d.irqMask);

    // Software reset is stretched so every consumer sees it.
    if (trigger) begin
      s_d.swCount = SW_HOLD;
    end else if (s_q.swCount != 4'h0) begin
      s_d.swCount = s_q.swCount - 4'h1;
    end
    // Released on a clock edge, once no request remains.
    s_d.mstRstN = ~anyReq;

    // Bus: capture the address phase; read data reflects the next state,
    // so a read right after a write sees the written value.
    s_d.dpWrite = addrPhase & ahbReq.hwrite;
    if (addrPhase) begin
      s_d.dpAddr = ahbReq.haddr[15:0];
    end
    if (addrPhase && !ahbReq.hwrite) begin
      s_d.hrdata = readReg(ahbReq.haddr[15:0], s_d);
    end
  end

  // Single state register; the status flags ride through the master reset.
  always_ff @(posedge core_clk or negedge rstLocalN) begin
    if (!rstLocalN) begin
      s_q <= '0;
      s_q.syncA <= `SRC_REQ_IDLE;
      s_q.syncB <= `SRC_REQ_IDLE;
      s_q.cause <= `SRC_CAUSE_POR_VALUE;
      s_q.irqStat <= 16'h0000;
      s_q.irqMask <= 16'h0000;
      s_q.mstRstN <= 1'b0;
      s_q.dpAddr <= 16'h0000;
      s_q.hrdata <= 32'h00000000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; the slave never stalls or errors.
  // One assignment drives the whole response, so no tool sees several writers of one variable.
  assign ahbRsp = '{hrdata: s_q.hrdata, hreadyout: 1'b1, hresp: 1'b0};
  assign masterSystemResetN = s_q.mstRstN;
  assign regulatorStandbyKeepOn = s_q.cause[`SRC_BIT_REGULATOR_STANDBY_KEEP_ON];
  assign irq = s_q.irq;

  // Checks of the behaviour above, all on the core clock.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstLocalN);

  // Any synchronised request asserts the master reset one edge later.
  a_master_any_req: assert property (
    (porReq || extReq || wdtReq || borReq || cmrReq) |=> !masterSystemResetN)
    else $error("master reset not asserted on request");

  // A trigger write keeps the reset asserted for the four cycles after it.
  a_sw_stretch: assert property (
    trigger |=> (!masterSystemResetN) [*4])
    else $error("software reset stretch too short");

  // A clear alias write lowers the written bits unless hardware sets them.
  a_alias_clear: assert property (
    (causeWr && dpAlias == src_pkg::SRC_ALIAS_CLR && hwSet == 16'h0000 && !porReq)
    |=> ((s_q.cause & $past(ahbReq.hwdata[15:0])) == 16'h0000))
    else $error("clear alias did not clear");

  // The upper halfword and unimplemented bits always read zero.
  a_unimpl_zero: assert property (
    (ahbRsp.hrdata[31:16] == 16'h0000) && ((s_q.cause & ~`SRC_CAUSE_MASK) == 16'h0000))
    else $error("unimplemented bits not zero");

  // External pin request leaves its flag set.
  a_ext_flag: assert property (
    extReq |=> s_q.cause[`SRC_BIT_EXTERNAL_PIN_FLAG])
    else $error("external pin flag not set");

  // Watchdog request leaves its flag set.
  a_wdt_flag: assert property (
    wdtReq |=> s_q.cause[`SRC_BIT_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not set");

  // Mismatch request leaves its flag set.
  a_cmr_flag: assert property (
    cmrReq && !porReq |=> s_q.cause[`SRC_BIT_CMR])
    else $error("mismatch flag not set");

  // Software trigger leaves its flag set.
  a_swr_flag: assert property (
    trigger |=> s_q.cause[`SRC_BIT_SWR])
    else $error("software reset flag not set");

  // Power-on leaves exactly the power-on image.
  a_por_image: assert property (
    porReq |=> (s_q.cause == `SRC_CAUSE_POR_VALUE))
    else $error("power-on image wrong");

  // Regulator output follows its bit.
  a_regulator_standby_keep_on_out: assert property (
    regulatorStandbyKeepOn == s_q.cause[`SRC_BIT_REGULATOR_STANDBY_KEEP_ON])
    else $error("regulator output mismatch");

  // The trigger register always reads zero.
  a_trig_zero: assert property (
    (addrPhase && !ahbReq.hwrite && ahbReq.haddr[15:0] == `SRC_OFF_TRIG)
    |=> (ahbRsp.hrdata == 32'h00000000))
    else $error("trigger register read nonzero");

  // Release only follows a cycle with no request.
  a_release_sync: assert property (
    $rose(masterSystemResetN) |-> !$past(anyReq))
    else $error("reset released with request active");

  // Sleep wake sets its flag.
  a_sleep_wake: assert property (
    (sleepMode && wakeEvent && !porReq) |=> s_q.cause[`SRC_BIT_SLEEP])
    else $error("sleep wake flag not set");

  // Idle wake sets its flag.
  a_idle_wake: assert property (
    (idleMode && wakeEvent && !porReq) |=> s_q.cause[`SRC_BIT_IDLE])
    else $error("idle wake flag not set");

  // Brown-out sets its flag.
  a_bor_flag: assert property (
    borReq |=> s_q.cause[`SRC_BIT_BOR])
    else $error("brown-out flag not set");

  // Interrupt is high exactly while an unmasked status bit is set.
  a_irq_level: assert property (
    irq == |(s_q.irqStat & s_q.irqMask))
    else $error("interrupt level mismatch");

  // Main scenarios.
  c_sw_reset: cover property (trigger ##1 !masterSystemResetN [*4] ##1 masterSystemResetN);
  c_wdt_reset: cover property (wdtReq ##[1:20] masterSystemResetN);
  c_ext_reset: cover property (extReq ##1 s_q.cause[`SRC_BIT_EXTERNAL_PIN_FLAG]);
  c_irq_raise: cover property ($rose(irq));

endmodule

/* tb/src_reset_combiner_tb_top.sv */
// Self-checking bench for the reset combiner: bus tasks, source requests, read monitor.
// Assumes the combiner package and constants header are compiled before it.
`timescale 1ns/1ps
`include "src_consts.svh"
module src_reset_combiner_tb_top;
  localparam logic [3:0] HOLD = 4'h3; // Shortened software reset stretch keeps runs brief.
  logic core_clk = 1'b0; // Bench clock, 10 ns period.
  logic rst_n = 1'b0; // Power-on reset of the combiner.
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rdPend = 1'b0; // High during a read data phase.
  src_pkg::src_req_t srcReq = `SRC_REQ_IDLE; // Pin idles high, others low.
  logic sleepMode = 1'b0;
  logic idleMode = 1'b0;
  logic wakeEvent = 1'b0;
  wire src_pkg::src_ahb_req_t busReq;
  src_pkg::src_ahb_rsp_t ahbRsp;
  logic masterSystemResetN;
  logic regulatorStandbyKeepOn;
  logic irq;
  logic [47:0] expQ[$]; // Address and expected read data, oldest first.
  logic [47:0] note;
  logic [31:0] d;
  int failures = 0;
  int num_checks = 0;
  int seed = 49;
  int n;
  localparam logic [15:0] CA = `SRC_OFF_CAUSE;
  localparam logic [15:0] ST = `SRC_OFF_IRQ_STAT;
  localparam logic [15:0] MK = `SRC_OFF_IRQ_MASK;

  // The slave's ready is the bus ready; word size always.
  assign busReq = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
                    hwdata: hwdata, hready: ahbRsp.hreadyout};

  always #5 core_clk = ~core_clk;

  src_reset_combiner #(.SW_HOLD(HOLD)) src_reset_combiner_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ahbReq(busReq),
    .ahbRsp(ahbRsp),
    .srcReq(srcReq),
    .sleepMode(sleepMode),
    .idleMode(idleMode),
    .wakeEvent(wakeEvent),
    .masterSystemResetN(masterSystemResetN),
    .regulatorStandbyKeepOn(regulatorStandbyKeepOn),
    .irq(irq)
  );

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Direct comparison of a settled output.
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic endTest(input string what);
    $display("test %s done", what);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Single write; the address phase holds until ready is seen high.
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge core_clk); while (ahbRsp.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge core_clk); while (ahbRsp.hreadyout !== 1'b1);
  endtask

  // Single read; the expected word is noted for the monitor.
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge core_clk); while (ahbRsp.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    rdPend <= 1'b1;
    expQ.push_back({a, e});
    do @(posedge core_clk); while (ahbRsp.hreadyout !== 1'b1);
    rdPend <= 1'b0;
  endtask

  // Waits a bounded time for the master reset to reach a level.
  task automatic waitRst(input logic lvl, input string what);
    int k;
    k = 0;
    #1;
    while (masterSystemResetN !== lvl && k < 16) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk(what, {31'h0, lvl}, {31'h0, masterSystemResetN});
  endtask

  // Flag that each source request leaves behind.
  function automatic int flagBit(input int k);
    case (k)
      1: return `SRC_BIT_EXTERNAL_PIN_FLAG;
      2: return `SRC_BIT_WATCHDOG_TIMEOUT_FLAG;
      3: return `SRC_BIT_BOR;
      default: return `SRC_BIT_CMR;
    endcase
  endfunction

  // Read data is taken at the edge that ends the data phase.
  always @(posedge core_clk) begin
    if (rdPend === 1'b1 && ahbRsp.hreadyout === 1'b1 && expQ.size() > 0) begin
      note = expQ.pop_front();
      num_checks++;
      if (ahbRsp.hrdata !== note[31:0]) begin
        failures++;
        $display("wrong value read %h expected %h seen %h", note[47:32], note[31:0],
                 ahbRsp.hrdata);
      end
      // The slave must answer every read with an OKAY response.
      chk("hresp", 32'h0, {31'h0, ahbRsp.hresp});
    end
  end

  // Cuts a hang short; the tests need a few hundred cycles.
  initial begin
    #200000;
    failures++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(6);
    waitRst(1'b1, "released");
    rd(CA, 32'h3);
    rd(`SRC_OFF_TRIG, 32'h0);
    rd(16'hF640, 32'h0);
    chk("standby", 32'h0, {31'h0, regulatorStandbyKeepOn});
    endTest("power-up");
    wr(CA + 16'h0004, 32'h3);
    rd(CA, 32'h0);
    wr(CA + 16'h0008, 32'h100);
    rd(CA, 32'h100);
    chk("standby", 32'h1, {31'h0, regulatorStandbyKeepOn});
    wr(CA + 16'h000C, 32'h100);
    rd(CA, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(CA + 16'h0008, d);
      rd(CA, d & {16'h0000, `SRC_CAUSE_MASK});
      wr(CA + 16'h0004, 32'hFFFFFFFF);
      rd(CA, 32'h0);
    end
    endTest("aliases");
    for (int k = 1; k < 5; k++) begin
      srcReq <= `SRC_REQ_IDLE ^ (5'h01 << k);
      waitRst(1'b0, "source reset");
      cyc(6);
      chk("held", 32'h0, {31'h0, masterSystemResetN});
      srcReq <= `SRC_REQ_IDLE;
      waitRst(1'b1, "source release");
      rd(CA, 32'h1 << flagBit(k));
      wr(CA + 16'h0004, 32'h3DF);
    end
    endTest("sources");
    wr(`SRC_OFF_TRIG, 32'h0);
    cyc(4);
    chk("no trigger", 32'h1, {31'h0, masterSystemResetN});
    wr(`SRC_OFF_TRIG, 32'h1);
    n = 0;
    #1;
    while (masterSystemResetN === 1'b0 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("stretch", {28'h0, HOLD} + 32'h1, n);
    rd(CA, 32'h40);
    rd(`SRC_OFF_TRIG, 32'h0);
    wr(CA + 16'h0004, 32'h3DF);
    for (int j = 0; j < 2; j++) begin
      sleepMode <= (j == 0);
      idleMode <= (j == 1);
      cyc(1);
      wakeEvent <= 1'b1;
      cyc(1);
      wakeEvent <= 1'b0;
      sleepMode <= 1'b0;
      idleMode <= 1'b0;
      cyc(1);
      rd(CA, (j == 0) ? 32'h8 : 32'h4);
      wr(CA + 16'h0004, 32'h3DF);
    end
    endTest("trigger and wake");
    wr(ST + 16'h0004, 32'hFFFF);
    wr(MK, 32'h10);
    cyc(2);
    chk("irq idle", 32'h0, {31'h0, irq});
    srcReq <= `SRC_REQ_IDLE ^ 5'h04;
    waitRst(1'b0, "watchdog reset");
    srcReq <= `SRC_REQ_IDLE;
    waitRst(1'b1, "watchdog release");
    cyc(2);
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(ST, 32'h10);
    wr(MK + 16'h0004, 32'h10);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MK + 16'h0008, 32'h10);
    cyc(2);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(ST, 32'h10);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ST + 16'h0008, 32'h40);
    rd(ST, 32'h40);
    wr(ST + 16'h000C, 32'h40);
    rd(ST, 32'h0);
    endTest("interrupt");
    wr(CA + 16'h0008, 32'h300);
    srcReq <= `SRC_REQ_IDLE ^ 5'h01;
    waitRst(1'b0, "power-on reset");
    cyc(3);
    srcReq <= `SRC_REQ_IDLE;
    waitRst(1'b1, "power-on release");
    rd(CA, 32'h3);
    chk("standby cleared", 32'h0, {31'h0, regulatorStandbyKeepOn});
    endTest("power-on request");
    cyc(2);
    end_sim();
  end
endmodule
